// ==== rtl/pmbus_ctl_defines.svh ====
// Purpose: constants for the PMBus output control register block
// Assumes: included by its bare name wherever the constants are needed
// Notes: command codes double as register offsets on the serial bus
`ifndef PMBUS_CTL_DEFINES_SVH
`define PMBUS_CTL_DEFINES_SVH

// command codes
`define CMD_OPERATION 8'h01
`define CMD_DEVICE_ID 8'had
`define CMD_DEVICE_REV 8'hae
`define CMD_SCRATCH 8'hd0
`define CMD_OPTIONS 8'he5
`define CMD_MISC 8'hf0

// reset values, block count and idle byte
`define SCRATCH_RST 16'h0000
`define OPTIONS_RST 16'h00c7
`define MISC_RST 16'h0001
`define OP_RST 2'h0
`define BLOCK_COUNT 8'h02
`define IDLE_BYTE 8'hff

// on/off register fields
`define OP_ON_BIT 7
`define OP_SOFT_BIT 6

// option register fields
`define OPT_ARA_BIT 0
`define OPT_ADC_EN_BIT 1
`define OPT_AUTO_LVL_BIT 2
`define OPT_LIMIT_OVR_BIT 3
`define OPT_SCAN_BIT 4
`define OPT_SS_DIS_BIT 5
`define OPT_AVG_LSB 6
`define OPT_FORCE_LVL_BIT 8

// misc register fields
`define MISC_OVP_BIT 0
`define MISC_FSYNC_BIT 1
`define MISC_HIGH_SIDE_OVERCURRENT_TRIM_LSB 4
`define MISC_HIGH_SIDE_OVERCURRENT_TRIM_W 4

// synchroniser reset levels: control pin, data, clock
`define PIN_RST 3'b011

`endif

// ==== rtl/pmbus_ctl_pkg.sv ====
// Purpose: types for the PMBus output control register block
// Assumes: nothing beyond the defines header
// Notes: bus state codes are one-hot
package pmbus_ctl_pkg;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RX = 6'h02,
      S_RACK = 6'h04,
      S_TX = 6'h08,
      S_TACK = 6'h10,
      S_WAIT = 6'h20
   } bus_state_t;

   typedef struct packed {
      logic switch_en;
      logic drivers_low;
      logic soft_stop;
      logic imm_off;
      logic low_side_on;
   } conv_ctl_t;

endpackage

// ==== rtl/pmbus_output_control_registers.sv ====
// Purpose: PMBus slave with the on/off, identity and option registers
// Assumes: bus pins and control pin are asynchronous to sys_clk_i
// Notes: bus clock must be well below a quarter of sys_clk_i
`timescale 1ns/10ps
`include "pmbus_ctl_defines.svh"

module pmbus_output_control_registers
   import pmbus_ctl_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = 7'h24,
   parameter logic [15:0] DEVICE_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_REV = 16'h0101 // arbitrary value
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic alert_o,
   output logic alert_oe_n_o,
   // converter conditions
   input wire logic control_pin_i,
   input wire logic control_pin_required_i,
   input wire logic opr_gating_i,
   input wire logic uvlo_ok_i,
   input wire logic fault_active_i,
   input wire logic soft_done_i,
   input wire logic ov_fault_i,
   input wire logic below_uv_i,
   input wire logic strap_valid_i,
   input wire logic clear_faults_i,
   // nonvolatile store
   input wire logic nvm_store_i,
   input wire logic nvm_restore_i,
   // converter controls and status
   output conv_ctl_t ctl_o,
   output logic sync_as_reset_o,
   output logic [1:0] margin_sel_o,
   output logic cml_o,
   output logic ivd_o,
   output logic [15:0] options_o,
   output logic [15:0] misc_o
);

   localparam logic [2:0] PIN_RST = `PIN_RST;

   // three-stage pin synchronisers with agreement filter
   logic [2:0] pin_in;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] f_r;
   logic [1:0] fd_r;
   assign pin_in = {control_pin_i, sda_i, scl_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge sys_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               s1_r[g] <= PIN_RST[g];
               s2_r[g] <= PIN_RST[g];
               s3_r[g] <= PIN_RST[g];
               f_r[g] <= PIN_RST[g];
            end else begin
               s1_r[g] <= pin_in[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  f_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   // previous filtered bus levels for edge detection
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fd_r <= 2'h3;
      end else begin
         fd_r <= f_r[1:0];
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   // start and stop only count while the clock stays high
   assign scl_rise = f_r[0] & ~fd_r[0];
   assign scl_fall = ~f_r[0] & fd_r[0];
   assign start = f_r[0] & fd_r[0] & fd_r[1] & ~f_r[1];
   assign stop = f_r[0] & fd_r[0] & ~fd_r[1] & f_r[1];

   // bus state
   bus_state_t st_r, st_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic rd_r, rd_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [7:0] d0_r, d0_nxt;
   logic [7:0] d1_r, d1_nxt;
   logic ackd_r, ackd_nxt;
   logic drv_r, drv_nxt;
   logic [1:0] n_r, n_nxt;
   logic [7:0] tb;

   // register state
   logic [1:0] op_r, op_nxt;
   logic [15:0] scr_r, scr_nxt;
   logic [15:0] opt_r, opt_nxt;
   logic [15:0] misc_r, misc_nxt;
   logic [15:0] nv_scr_r, nv_scr_nxt;
   logic [15:0] nv_opt_r, nv_opt_nxt;
   logic [15:0] nv_misc_r, nv_misc_nxt;
   logic cml_r, cml_nxt;
   logic ivd_r, ivd_nxt;

   // read data: byte n of the answer to command c
   function automatic logic [7:0] tx_byte(input logic [7:0] c,
                                          input logic [1:0] n,
                                          input logic [1:0] op,
                                          input logic [15:0] scr,
                                          input logic [15:0] opt,
                                          input logic [15:0] misc);
      logic [15:0] w;
      logic blk;
      w = 16'h0000;
      blk = 1'b0;
      if (c == `CMD_OPERATION) begin
         w = {8'h00, op, 6'h00};
      end else if (c == `CMD_DEVICE_ID) begin
         w = DEVICE_ID;
         blk = 1'b1;
      end else if (c == `CMD_DEVICE_REV) begin
         w = DEVICE_REV;
         blk = 1'b1;
      end else if (c == `CMD_SCRATCH) begin
         w = scr;
      end else if (c == `CMD_OPTIONS) begin
         w = opt;
      end else if (c == `CMD_MISC) begin
         w = misc;
      end
      if (blk) begin
         // count byte, then low, then high
         case (n)
            2'h0: tx_byte = `BLOCK_COUNT;
            2'h1: tx_byte = w[7:0];
            2'h2: tx_byte = w[15:8];
            default: tx_byte = `IDLE_BYTE;
         endcase
      end else begin
         case (n)
            2'h0: tx_byte = w[7:0];
            2'h1: tx_byte = w[15:8];
            default: tx_byte = `IDLE_BYTE;
         endcase
      end
   endfunction

   assign tb = tx_byte(cmd_r, n_r, op_r, scr_r, opt_r, misc_r);

   // bus byte engine; a restart keeps the command for a read
   always_comb begin
      st_nxt = st_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      idx_nxt = idx_r;
      rd_nxt = rd_r;
      cmd_nxt = cmd_r;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      ackd_nxt = ackd_r;
      drv_nxt = drv_r;
      n_nxt = n_r;
      if (stop) begin
         st_nxt = S_IDLE;
         drv_nxt = 1'b0;
      end else if (start) begin
         st_nxt = S_RX;
         bit_nxt = 4'h0;
         idx_nxt = 3'h0;
         n_nxt = 2'h0;
         drv_nxt = 1'b0;
      end else begin
         case (st_r)
            S_RX: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], f_r[1]};
                  bit_nxt = bit_r + 4'h1;
               end else if (scl_fall && bit_r == 4'h8) begin
                  bit_nxt = 4'h0;
                  st_nxt = S_RACK;
                  drv_nxt = 1'b1;
                  if (idx_r != 3'h7) begin
                     idx_nxt = idx_r + 3'h1;
                  end
                  if (idx_r == 3'h0) begin
                     rd_nxt = sh_r[0];
                     if (sh_r[7:1] != BUS_ADDR) begin
                        st_nxt = S_WAIT;
                        drv_nxt = 1'b0;
                     end
                  end else if (idx_r == 3'h1) begin
                     cmd_nxt = sh_r;
                  end else if (idx_r == 3'h2) begin
                     d0_nxt = sh_r;
                  end else if (idx_r == 3'h3) begin
                     d1_nxt = sh_r;
                  end
               end
            end
            S_RACK: begin
               if (scl_fall && rd_r) begin
                  st_nxt = S_TX;
                  sh_nxt = tb;
                  drv_nxt = ~tb[7];
                  n_nxt = (n_r == 2'h3) ? n_r : n_r + 2'h1;
               end else if (scl_fall) begin
                  st_nxt = S_RX;
                  drv_nxt = 1'b0;
               end
            end
            S_TX: begin
               if (scl_fall && bit_r == 4'h7) begin
                  st_nxt = S_TACK;
                  bit_nxt = 4'h0;
                  drv_nxt = 1'b0;
               end else if (scl_fall) begin
                  sh_nxt = {sh_r[6:0], 1'b1};
                  bit_nxt = bit_r + 4'h1;
                  drv_nxt = ~sh_r[6];
               end
            end
            S_TACK: begin
               if (scl_rise) begin
                  ackd_nxt = ~f_r[1];
               end else if (scl_fall && ackd_r) begin
                  st_nxt = S_TX;
                  sh_nxt = tb;
                  drv_nxt = ~tb[7];
                  n_nxt = (n_r == 2'h3) ? n_r : n_r + 2'h1;
               end else if (scl_fall) begin
                  st_nxt = S_WAIT;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= S_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         idx_r <= 3'h0;
         rd_r <= 1'b0;
         cmd_r <= 8'h00;
         d0_r <= 8'h00;
         d1_r <= 8'h00;
         ackd_r <= 1'b0;
         drv_r <= 1'b0;
         n_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         idx_r <= idx_nxt;
         rd_r <= rd_nxt;
         cmd_r <= cmd_nxt;
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         ackd_r <= ackd_nxt;
         drv_r <= drv_nxt;
         n_r <= n_nxt;
      end
   end

   // a write is whole only if stop follows an acked byte; the stop's own
   // clock rise is counted as one bit, sampled while data is still low
   logic wr_done;
   logic one_byte;
   logic two_byte;
   logic bad_op;
   assign wr_done = stop & (st_r == S_RX) & (bit_r == 4'h1) & ~sh_r[0] &
                    ~rd_r;
   assign one_byte = wr_done & (idx_r == 3'h3);
   assign two_byte = wr_done & (idx_r == 3'h4);
   assign bad_op = one_byte & (cmd_r == `CMD_OPERATION) &
                   d0_r[`OP_ON_BIT] & d0_r[`OP_SOFT_BIT];

   // register updates, nonvolatile shadow and invalid-data flags
   always_comb begin
      op_nxt = op_r;
      scr_nxt = scr_r;
      opt_nxt = opt_r;
      misc_nxt = misc_r;
      nv_scr_nxt = nv_scr_r;
      nv_opt_nxt = nv_opt_r;
      nv_misc_nxt = nv_misc_r;
      if (one_byte && cmd_r == `CMD_OPERATION && !bad_op) begin
         // bits 5..0 are dropped
         op_nxt = {d0_r[`OP_ON_BIT], d0_r[`OP_SOFT_BIT]};
      end else if (two_byte && cmd_r == `CMD_SCRATCH) begin
         scr_nxt = {d1_r, d0_r};
      end else if (two_byte && cmd_r == `CMD_OPTIONS) begin
         opt_nxt = {d1_r, d0_r};
      end else if (two_byte && cmd_r == `CMD_MISC) begin
         misc_nxt = {d1_r, d0_r};
      end
      // identity commands and bad lengths fall through unchanged
      if (nvm_restore_i) begin
         scr_nxt = nv_scr_r;
         opt_nxt = nv_opt_r;
         misc_nxt = nv_misc_r;
      end else if (nvm_store_i) begin
         nv_scr_nxt = scr_r;
         nv_opt_nxt = opt_r;
         nv_misc_nxt = misc_r;
      end
      // a new invalid write beats a clear in the same cycle
      cml_nxt = bad_op | (cml_r & ~clear_faults_i);
      ivd_nxt = bad_op | (ivd_r & ~clear_faults_i);
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         op_r <= `OP_RST;
         scr_r <= `SCRATCH_RST;
         opt_r <= `OPTIONS_RST;
         misc_r <= `MISC_RST;
         nv_scr_r <= `SCRATCH_RST;
         nv_opt_r <= `OPTIONS_RST;
         nv_misc_r <= `MISC_RST;
         cml_r <= 1'b0;
         ivd_r <= 1'b0;
      end else begin
         op_r <= op_nxt;
         scr_r <= scr_nxt;
         opt_r <= opt_nxt;
         misc_r <= misc_nxt;
         nv_scr_r <= nv_scr_nxt;
         nv_opt_r <= nv_opt_nxt;
         nv_misc_r <= nv_misc_nxt;
         cml_r <= cml_nxt;
         ivd_r <= ivd_nxt;
      end
   end

   // converter control
   conv_ctl_t ctl_r, ctl_nxt;
   logic soft_r, soft_nxt;
   logic sar_r, sar_nxt;
   logic run;
   logic ok;
   assign run = op_r[1] & opr_gating_i &
                (~control_pin_required_i | f_r[2]);
   assign ok = uvlo_ok_i & ~fault_active_i;

   always_comb begin
      ctl_nxt = ctl_r;
      soft_nxt = soft_r;
      ctl_nxt.imm_off = 1'b0;
      ctl_nxt.soft_stop = 1'b0;
      if (run && ok) begin
         ctl_nxt.switch_en = 1'b1;
         soft_nxt = 1'b0;
      end else if (ctl_r.switch_en && !soft_r && ok &&
                   op_r[0] && !op_r[1]) begin
         soft_nxt = 1'b1;
         ctl_nxt.soft_stop = 1'b1;
      end else if (soft_r) begin
         // keep switching through the ramp unless a fault cuts in
         if (soft_done_i || !ok) begin
            ctl_nxt.switch_en = 1'b0;
            soft_nxt = 1'b0;
         end
      end else if (ctl_r.switch_en) begin
         ctl_nxt.switch_en = 1'b0;
         ctl_nxt.imm_off = 1'b1;
      end
      ctl_nxt.drivers_low = ~ctl_nxt.switch_en;
      // release on undervoltage when the response bit is set
      ctl_nxt.low_side_on = ov_fault_i | (ctl_r.low_side_on &
         ~(misc_r[`MISC_OVP_BIT] ? below_uv_i : clear_faults_i));
      sar_nxt = ~misc_r[`MISC_FSYNC_BIT] & strap_valid_i;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_r <= 5'b01000;
         soft_r <= 1'b0;
         sar_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         soft_r <= soft_nxt;
         sar_r <= sar_nxt;
      end
   end

   // open-drain pins: enable low while pulling low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~drv_r;
   assign alert_o = 1'b0;
   assign alert_oe_n_o = ~cml_r;
   assign ctl_o = ctl_r;
   assign sync_as_reset_o = sar_r;
   // margin codes live in read-only bits, so nominal stays chosen
   assign margin_sel_o = 2'h0;
   assign cml_o = cml_r;
   assign ivd_o = ivd_r;
   assign options_o = opt_r;
   assign misc_o = misc_r;

endmodule

// ==== dv/pmbus_ctl_checker.sv ====
// Purpose: port assertions for the output control register block
// Assumes: one clock domain, reset active low
// Notes: latencies follow the hand-over timing of the block
`timescale 1ns/10ps
module pmbus_ctl_checker
   import pmbus_ctl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // pins
   input wire logic sda_o,
   input wire logic alert_o,
   input wire logic alert_oe_n_o,
   // converter conditions
   input wire logic opr_gating_i,
   input wire logic uvlo_ok_i,
   input wire logic fault_active_i,
   input wire logic ov_fault_i,
   input wire logic below_uv_i,
   input wire logic strap_valid_i,
   input wire logic clear_faults_i,
   // controls and status
   input conv_ctl_t ctl_o,
   input wire logic sync_as_reset_o,
   input wire logic [1:0] margin_sel_o,
   input wire logic cml_o,
   input wire logic ivd_o,
   input wire logic [15:0] options_o,
   input wire logic [15:0] misc_o
);
   // everything here runs on the system clock
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   drivers_off_a: assert property (
      ctl_o.switch_en != ctl_o.drivers_low)
      else $error("switch enable and drivers low disagree");
   start_gate_a: assert property (
      $rose(ctl_o.switch_en) |-> $past(uvlo_ok_i) && $past(opr_gating_i)
      && !$past(fault_active_i))
      else $error("switching started without its conditions");
   imm_off_a: assert property (
      ctl_o.imm_off |=> !ctl_o.imm_off && !ctl_o.switch_en)
      else $error("immediate off left switching on");
   soft_stop_a: assert property (
      ctl_o.soft_stop |-> ctl_o.switch_en ##1 !ctl_o.soft_stop)
      else $error("soft stop did not hold switching");
   alert_a: assert property (
      $rose(cml_o) |-> ivd_o ##[0:1] !alert_oe_n_o)
      else $error("invalid data without alert");
   sticky_flag_a: assert property (
      $fell(cml_o) |-> $past(clear_faults_i) || $past(clear_faults_i, 2))
      else $error("flag dropped without clear");
   low_side_a: assert property (
      $rose(ctl_o.low_side_on) |-> $past(ov_fault_i))
      else $error("low switch latched without fault");
   low_release_a: assert property (
      $fell(ctl_o.low_side_on) |-> $past(clear_faults_i)
      || ($past(below_uv_i) && $past(misc_o[0])))
      else $error("low switch released early");
   sync_pin_a: assert property (
      $past(resetn_i) |-> sync_as_reset_o ==
      ($past(strap_valid_i) && !$past(misc_o[1])))
      else $error("shared pin mode wrong");
   margin_a: assert property (
      margin_sel_o == 2'h0 && !sda_o && !alert_o)
      else $error("margin or pin level wrong");
   reset_val_a: assert property (
      $rose(resetn_i) |-> options_o == 16'h00c7 && misc_o == 16'h0001)
      else $error("option reset values wrong");
endmodule

bind pmbus_output_control_registers pmbus_ctl_checker pmbus_ctl_checker_i (
   .sys_clk_i, .resetn_i, .sda_o, .alert_o, .alert_oe_n_o, .opr_gating_i,
   .uvlo_ok_i, .fault_active_i, .ov_fault_i, .below_uv_i, .strap_valid_i,
   .clear_faults_i, .ctl_o, .sync_as_reset_o, .margin_sel_o, .cml_o,
   .ivd_o, .options_o, .misc_o);

// ==== dv/pmbus_host_model.sv ====
// Purpose: bus master model for the serial register bus
// Assumes: data line has a pull-up, device pulls it via its enable
// Notes: clock rests high between frames; low six clocks, high two
`timescale 1ns/10ps
module pmbus_host_model #(
   parameter logic [6:0] ADDR = 7'h24
) (
   // clock
   input wire logic clk_i,
   // bus pins
   input wire logic sda_oe_n_i,
   output logic scl_o,
   output logic sda_o
);
   logic pull = 1'b0;
   // wired-and: a released line floats up, never holds a stale bit
   assign sda_o = !(pull || !sda_oe_n_i);
   initial scl_o = 1'b1;
   task automatic q();
      repeat (2) @(posedge clk_i);
   endtask
   // the device answers five clocks after a fall, so the low phase is
   // long; data is sampled at the end of the high phase
   task automatic slot(input logic b, output logic r);
      q();
      pull <= !b;
      q();
      q();
      scl_o <= 1'b1;
      q();
      r = sda_o;
      scl_o <= 1'b0;
   endtask
   // start or repeated start, from either clock level; the first wait
   // lets the device drop its acknowledge before the clock rises
   task automatic start();
      q();
      q();
      pull <= 1'b0;
      q();
      scl_o <= 1'b1;
      q();
      pull <= 1'b1;
      q();
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      q();
      q();
      pull <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      pull <= 1'b0;
      q();
   endtask
   task automatic put(input logic [7:0] b, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) slot(b[i], r);
      slot(1'b1, r);
      ok = !r;
   endtask
   // last byte gets a nack to end the device's transmission
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(last, r);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d,
      input int n, input logic abort, output logic ok);
      logic a;
      logic b;
      start();
      put({ADDR, 1'b0}, a);
      put(c, b);
      ok = a && b;
      for (int i = 0; i < n; i++) begin
         put(d[8*i +: 8], b);
         ok = ok && b;
      end
      if (abort) start();
      stop();
   endtask
   task automatic rd(input logic [7:0] c, input int n,
      output logic [23:0] d, output logic ok);
      logic a;
      logic b;
      d = 24'h0;
      start();
      put({ADDR, 1'b0}, a);
      put(c, b);
      ok = a && b;
      start();
      put({ADDR, 1'b1}, b);
      ok = ok && b;
      for (int i = 0; i < n; i++) get(i == n - 1, d[8*i +: 8]);
      stop();
   endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the output control registers
// Assumes: host model drives the bus pins
// Notes: expected values are fixed figures, never read from the design
`timescale 1ns/10ps
`include "pmbus_ctl_defines.svh"
module tb;
   import pmbus_ctl_pkg::*;
   localparam logic [15:0] ID_V = 16'h5a3c; // arbitrary value
   localparam logic [15:0] REV_V = 16'h0102; // arbitrary value
   logic clk, rst_n, cpin, creq, gate, uvlo, flt, sdone, ov, buv, strap;
   logic clr, nst, nrs, scl, sda, sda_oe_n, al_oe_n, cml, ivd, syr;
   logic [1:0] mrg;
   logic [15:0] opts, misc;
   conv_ctl_t ctl;
   int error_cnt = 0;
   int n_compared = 0;
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   pmbus_host_model pmbus_host_model_i (.clk_i(clk), .sda_oe_n_i(sda_oe_n),
      .scl_o(scl), .sda_o(sda));
   pmbus_output_control_registers #(.DEVICE_ID(ID_V), .DEVICE_REV(REV_V))
      pmbus_output_control_registers_i (.sys_clk_i(clk), .resetn_i(rst_n),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
      .alert_o(), .alert_oe_n_o(al_oe_n), .control_pin_i(cpin),
      .control_pin_required_i(creq), .opr_gating_i(gate), .uvlo_ok_i(uvlo),
      .fault_active_i(flt), .soft_done_i(sdone), .ov_fault_i(ov),
      .below_uv_i(buv), .strap_valid_i(strap), .clear_faults_i(clr),
      .nvm_store_i(nst), .nvm_restore_i(nrs), .ctl_o(ctl),
      .sync_as_reset_o(syr), .margin_sel_o(mrg), .cml_o(cml), .ivd_o(ivd),
      .options_o(opts), .misc_o(misc));
   task automatic check(input string what, input logic [39:0] seen,
      input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // settle long enough for the synchronised stop to commit
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n,
      input logic abort = 1'b0);
      logic ok;
      pmbus_host_model_i.wr(c, d, n, abort, ok);
      check("ack", ok, 1'b1);
      repeat (8) @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] c, input int n, input logic [23:0] e);
      logic [23:0] d;
      logic ok;
      pmbus_host_model_i.rd(c, n, d, ok);
      check("read", {ok, d}, {1'b1, e});
   endtask
   // bounded wait on switching; running out ends the run
   task automatic wait_en(input logic v);
      int k;
      k = 0;
      while (ctl.switch_en !== v && k < 40) begin
         @(posedge clk);
         k++;
      end
      check("switch_en", {ctl.switch_en, ctl.drivers_low}, {v, !v});
      if (k >= 40) give_verdict();
   endtask
   initial begin
      {cpin, creq, flt, sdone, ov, buv, clr, nst, nrs} = 9'h0;
      {gate, uvlo, strap} = 3'h7;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("ports", {opts, misc, syr, mrg}, {32'h00c70001, 3'h4});
      check("drivers", {ctl.switch_en, ctl.drivers_low}, 2'h1);
      rd(`CMD_OPTIONS, 2, 24'h00c7);
      rd(`CMD_MISC, 2, 24'h0001);
      rd(`CMD_SCRATCH, 2, 24'h0000);
      rd(`CMD_OPERATION, 1, 24'h0);
      rd(`CMD_DEVICE_REV, 3, {REV_V, 8'h02});
      wr(`CMD_DEVICE_ID, 16'hffff, 2);
      rd(`CMD_DEVICE_ID, 3, {ID_V, 8'h02});
      // each writable word: write, read back low byte first
      wr(`CMD_SCRATCH, 16'hbeef, 2);
      rd(`CMD_SCRATCH, 2, 24'hbeef);
      wr(`CMD_OPTIONS, 16'h0138, 2);
      rd(`CMD_OPTIONS, 2, 24'h0138);
      wr(`CMD_MISC, 16'h00f3, 2);
      rd(`CMD_MISC, 2, 24'h00f3);
      check("ports", {opts, misc, syr}, {32'h013800f3, 1'b0});
      nst <= 1'b1;
      @(posedge clk);
      nst <= 1'b0;
      wr(`CMD_SCRATCH, 16'h1111, 2);
      nrs <= 1'b1;
      @(posedge clk);
      nrs <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`CMD_SCRATCH, 2, 24'hbeef);
      wr(`CMD_MISC, 16'h0001, 2);
      wr(`CMD_OPERATION, 16'h0080, 1);
      wait_en(1'b1);
      rd(`CMD_OPERATION, 1, 24'h80);
      wr(`CMD_OPERATION, 16'h00c0, 1);
      check("flags", {cml, ivd, al_oe_n}, 3'h6);
      rd(`CMD_OPERATION, 1, 24'h80);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (4) @(posedge clk);
      check("flags", {cml, ivd, al_oe_n}, 3'h1);
      wr(`CMD_OPERATION, 16'h0000, 1, 1'b1);
      wait_en(1'b1);
      wr(`CMD_OPERATION, 16'h00bf, 1);
      rd(`CMD_OPERATION, 1, 24'h80);
      wr(`CMD_OPERATION, 16'h0040, 1);
      wait_en(1'b1);
      sdone <= 1'b1;
      @(posedge clk);
      sdone <= 1'b0;
      wait_en(1'b0);
      wr(`CMD_OPERATION, 16'h0080, 1);
      wait_en(1'b1);
      wr(`CMD_OPERATION, 16'h0000, 1);
      wait_en(1'b0);
      flt <= 1'b1;
      wr(`CMD_OPERATION, 16'h0080, 1);
      wait_en(1'b0);
      flt <= 1'b0;
      wr(`CMD_OPERATION, 16'h0000, 1);
      // control pin gating: mode returns when the pin does
      {creq, cpin} <= 2'h3;
      wr(`CMD_OPERATION, 16'h0080, 1);
      wait_en(1'b1);
      cpin <= 1'b0;
      wait_en(1'b0);
      cpin <= 1'b1;
      wait_en(1'b1);
      ov <= 1'b1;
      repeat (6) @(posedge clk);
      check("low_side_on", ctl.low_side_on, 1'b1);
      {ov, buv} <= 2'h1;
      repeat (6) @(posedge clk);
      check("low_side_on", ctl.low_side_on, 1'b0);
      check("margin", mrg, 2'h0);
      give_verdict();
   end
endmodule
